// [include/ple_pkg.sv]
package ple_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock
  localparam int unsigned PLE_CLOCK_HZ = 25_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the management interface
  localparam logic [4:0] PLE_OFS_LOOP_CTRL = 5'h13;
  localparam logic [4:0] PLE_OFS_ERR_COUNT = 5'h14;
  localparam logic [4:0] PLE_OFS_ENERGY_CTRL = 5'h15;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [15:0] PLE_LOOP_CTRL_RESET = 16'h1041;
  localparam logic [15:0] PLE_ERR_COUNT_RESET = 16'h0000;
  localparam logic [15:0] PLE_ENERGY_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PLE_LOOP_CTRL_WMASK = 16'h16C1;
  localparam logic [15:0] PLE_ENERGY_CTRL_WMASK = 16'h000C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PLE_BIT_ALL_DIGITAL_LOOP = 12;
  localparam int PLE_BIT_LINE_DRIVER_LOOP = 10;
  localparam int PLE_BIT_FAR_END_LOOP = 9;
  localparam int PLE_BIT_CABLE_LOOP = 7;
  localparam int PLE_BIT_LOOP_TX_SUPPRESS = 6;
  localparam int PLE_BIT_LOOP_LINK_OK = 0;
  localparam int PLE_BIT_ENERGY_PD_ENABLE = 3;
  localparam int PLE_BIT_PD_PULSE_ENABLE = 2;
  localparam int PLE_BIT_IN_ENERGY_PD = 1;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned PLE_ENERGY_IDLE_S = 3;
  localparam int unsigned PLE_ENERGY_IDLE_CYCLES = PLE_ENERGY_IDLE_S * PLE_CLOCK_HZ;
  localparam int unsigned PLE_PULSE_PERIOD_MS = 1000;
  localparam int unsigned PLE_PULSE_PERIOD_CYCLES = PLE_PULSE_PERIOD_MS * (PLE_CLOCK_HZ / 1000);
  localparam logic [1:0] PLE_STRAP_SETTLE_CYCLES = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // power-down states
  typedef enum logic {
    PLE_PD_AWAKE = 1'b0,
    PLE_PD_ASLEEP = 1'b1
  } ple_pd_state_type;

endpackage

// [verification/ple_loop_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ple_loop_regs_chk
  import ple_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mgmt_rd,
  input wire logic mgmt_rvalid,
  input wire logic ieee_loopback,
  input wire logic link_up,
  input wire logic [DATA_W-1:0] mac_txd,
  input wire logic mac_tx_en,
  input wire logic [DATA_W-1:0] ana_rxd,
  input wire logic [DATA_W-1:0] mac_rxd,
  input wire logic mac_rx_dv,
  input wire logic [DATA_W-1:0] ana_txd,
  input wire logic ana_tx_en,
  input wire logic all_digital_loop_active,
  input wire logic line_driver_loop_active,
  input wire logic far_end_loop_active,
  input wire logic cable_loop_active,
  input wire logic mdi_tx_suppress,
  input wire logic link_ok,
  input wire logic in_energy_powerdown,
  input wire logic powerdown_pulse_burst
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property ($past(rst_b) |-> mgmt_rvalid == $past(mgmt_rd))
    else $error("read answer out of step with read strobe");
  digital_loop_a: assert property (all_digital_loop_active |->
    mac_rxd == $past(mac_txd) && mac_rx_dv == $past(mac_tx_en))
    else $error("loopback receive data differs from transmit data");
  loop_gate_a: assert property (all_digital_loop_active |-> $past(ieee_loopback))
    else $error("digital loopback active without base loopback");
  line_driver_a: assert property (line_driver_loop_active |->
    $past(ieee_loopback) && !all_digital_loop_active)
    else $error("line driver loopback out of place");
  far_end_a: assert property (far_end_loop_active |->
    ana_txd == $past(ana_rxd) && $past(link_up) && !$past(ieee_loopback))
    else $error("far end loopback data or condition wrong");
  cable_loop_a: assert property (cable_loop_active |-> !$past(ieee_loopback))
    else $error("cable loopback with base loopback set");
  tx_suppress_a: assert property (mdi_tx_suppress |->
    all_digital_loop_active && !ana_tx_en)
    else $error("suppress wrong or transmit enable not muted");
  link_force_a: assert property ($past(rst_b) && $past(link_up) |-> link_ok)
    else $error("link ok low while link is up");
  pulse_asleep_a: assert property (powerdown_pulse_burst |->
    in_energy_powerdown ##1 !powerdown_pulse_burst)
    else $error("pulse burst outside power-down or too long");
  ////////////////////////////////////////////////////////////////////////////
  cover property (all_digital_loop_active && mdi_tx_suppress);
  cover property (far_end_loop_active);
  cover property (powerdown_pulse_burst);
endmodule
bind ple_loop_regs ple_loop_regs_chk #(.DATA_W(DATA_W)) u_chk (.clock, .rst_b, .mgmt_rd,
  .mgmt_rvalid, .ieee_loopback, .link_up, .mac_txd, .mac_tx_en, .ana_rxd, .mac_rxd,
  .mac_rx_dv, .ana_txd, .ana_tx_en, .all_digital_loop_active, .line_driver_loop_active,
  .far_end_loop_active, .cable_loop_active, .mdi_tx_suppress, .link_ok,
  .in_energy_powerdown, .powerdown_pulse_burst);
`default_nettype wire

// [verification/tb_ple_loop_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ple_loop_regs;
  import ple_pkg::*;
  logic clock, rst_b, mgmt_wr, mgmt_rd, mgmt_rvalid, ieee_loopback, link_up;
  logic diagnostics_clock_enable, frame_check_error, energy_detect_pin;
  logic energy_pd_strap_pin, pd_pulse_strap_pin, mac_tx_en, mac_tx_er, ana_rx_dv, ana_rx_er;
  logic mac_rx_dv, mac_rx_er, ana_tx_en, ana_tx_er, all_digital_loop_active, link_ok;
  logic line_driver_loop_active, far_end_loop_active, cable_loop_active, mdi_tx_suppress;
  logic in_energy_powerdown, powerdown_pulse_burst;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, em;
  logic [7:0] mac_txd, ana_rxd, mac_rxd, ana_txd;
  int failures, cmp_count, m_cnt, pulses;
  localparam logic [15:0] MODE_REG [7] = '{16'h1041, 16'h1000, 16'h0400, 16'h1400,
    16'h0200, 16'h0080, 16'h0081};
  localparam logic [1:0] MODE_IL [7] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h1, 2'h0, 2'h2};

  ple_loop_regs #(.DATA_W(8), .ENERGY_IDLE_CYCLES(20), .PULSE_PERIOD_CYCLES(8)) u_ple_loop_regs (
    .clock, .rst_b, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
    .ieee_loopback, .diagnostics_clock_enable, .link_up, .frame_check_error,
    .energy_detect_pin, .energy_pd_strap_pin, .pd_pulse_strap_pin, .mac_txd, .mac_tx_en,
    .mac_tx_er, .ana_rxd, .ana_rx_dv, .ana_rx_er, .mac_rxd, .mac_rx_dv, .mac_rx_er, .ana_txd,
    .ana_tx_en, .ana_tx_er, .all_digital_loop_active, .line_driver_loop_active,
    .far_end_loop_active, .cable_loop_active, .mdi_tx_suppress, .link_ok,
    .in_energy_powerdown, .powerdown_pulse_burst);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] modes(input logic [15:0] r, input logic ie, input logic lk);
    logic ad;
    ad = r[12] & ie;
    return {10'h000, ad, r[10] & ie & ~ad, r[9] & lk & ~ie, r[7] & ~ie, ad & r[6],
      lk | (ie & r[0])};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clock);
    mgmt_wr = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clock);
    mgmt_rd = 1'b0;
    chk(nm, exp, mgmt_rdata);
    chk("read valid", 16'h0001, {15'h0000, mgmt_rvalid});
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    #(40 * 4000);
    failures++;
    close_out();
  end

  initial begin
    void'($urandom(83006));
    {rst_b, mgmt_wr, mgmt_rd, ieee_loopback, link_up, diagnostics_clock_enable} = 6'h00;
    {frame_check_error, energy_pd_strap_pin, pd_pulse_strap_pin} = 3'h0;
    {mac_tx_en, mac_tx_er, ana_rx_dv, ana_rx_er} = 4'h0;
    {mgmt_addr, mgmt_wdata, mac_txd, ana_rxd} = 37'h0;
    energy_detect_pin = 1'b1;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    rd(PLE_OFS_LOOP_CTRL, 16'h1041, "loop reset");
    rd(PLE_OFS_ERR_COUNT, 16'h0000, "count reset");
    rd(PLE_OFS_ENERGY_CTRL, 16'h0000, "energy reset");
    wr(PLE_OFS_LOOP_CTRL, 16'hFFFF);
    rd(PLE_OFS_LOOP_CTRL, 16'h16C1, "loop reserved");
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000, "unmapped");
    wr(PLE_OFS_ENERGY_CTRL, 16'hFFF3);
    rd(PLE_OFS_ENERGY_CTRL, 16'h0000, "energy reserved");
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      diagnostics_clock_enable = k[0];
      m_cnt = 0;
      repeat (30) begin
        @(negedge clock);
        frame_check_error = 1'($urandom);
        if (frame_check_error) m_cnt += k;
      end
      @(negedge clock);
      frame_check_error = 1'b0;
      rd(PLE_OFS_ERR_COUNT, 16'(m_cnt), "error count");
      rd(PLE_OFS_ERR_COUNT, 16'h0000, "count cleared");
    end
    $display("test error counter done");
    for (int i = 0; i < 7; i++) begin
      wr(PLE_OFS_LOOP_CTRL, MODE_REG[i]);
      ieee_loopback = MODE_IL[i][1];
      link_up = MODE_IL[i][0];
      em = modes(MODE_REG[i], ieee_loopback, link_up);
      repeat (2) @(negedge clock);
      chk("modes", em, {10'h000, all_digital_loop_active, line_driver_loop_active,
        far_end_loop_active, cable_loop_active, mdi_tx_suppress, link_ok});
      repeat (12) begin
        {mac_tx_er, mac_tx_en, mac_txd, ana_rx_er, ana_rx_dv, ana_rxd} = 20'($urandom);
        @(negedge clock);
        if (em[5]) chk("loop rx", {6'h00, mac_tx_er, mac_tx_en, mac_txd},
          {6'h00, mac_rx_er, mac_rx_dv, mac_rxd});
        if (em[3]) chk("far end tx", {6'h00, ana_rx_er, ana_rx_dv, ana_rxd},
          {6'h00, ana_tx_er, ana_tx_en, ana_txd});
        if (em[1]) chk("tx muted", 16'h0000, {15'h0000, ana_tx_en});
      end
    end
    $display("test loop modes done");
    ieee_loopback = 1'b0;
    link_up = 1'b0;
    @(negedge clock);
    energy_pd_strap_pin = 1'b1;
    pd_pulse_strap_pin = 1'b1;
    rst_b = 1'b0;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    rd(PLE_OFS_ENERGY_CTRL, 16'h000C, "strap default");
    rd(PLE_OFS_LOOP_CTRL, 16'h1041, "loop reset again");
    energy_detect_pin = 1'b0;
    repeat (10) @(negedge clock);
    chk("early sleep", 16'h0000, {15'h0000, in_energy_powerdown});
    pulses = 0;
    repeat (50) begin
      @(negedge clock);
      if (powerdown_pulse_burst === 1'b1) pulses++;
    end
    chk("asleep", 16'h0001, {15'h0000, in_energy_powerdown});
    chk("pulses seen", 16'h0001, {15'h0000, pulses > 0});
    rd(PLE_OFS_ENERGY_CTRL, 16'h000E, "asleep status");
    wr(PLE_OFS_ENERGY_CTRL, 16'h0008);
    repeat (2) @(negedge clock);
    pulses = 0;
    repeat (30) begin
      @(negedge clock);
      if (powerdown_pulse_burst === 1'b1) pulses++;
    end
    chk("no pulses", 16'h0000, 16'(pulses));
    energy_detect_pin = 1'b1;
    repeat (6) @(negedge clock);
    chk("awake", 16'h0000, {15'h0000, in_energy_powerdown});
    rd(PLE_OFS_ENERGY_CTRL, 16'h0008, "awake status");
    $display("test energy power-down done");
    close_out();
  end
endmodule
`default_nettype wire

// [verilog/ple_energy_pd.sv]
`timescale 1ns/1ps
`default_nettype none

module ple_energy_pd
  import ple_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = PLE_ENERGY_IDLE_CYCLES,
  parameter int unsigned PULSE_CYCLES = PLE_PULSE_PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic pulse_enable,
  input wire logic energy_seen,
  output logic in_powerdown_q,
  output logic wake_pulse_q
);

  ////////////////////////////////////////////////////////////////////////////
  // idle timer and pulse period timer share one counter
  ple_pd_state_type state_q;
  ple_pd_state_type state_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic wake_pulse_d;

  wire abort = !enable || energy_seen;
  wire idle_done = count_q == (IDLE_CYCLES - 32'd1);
  wire pulse_done = count_q == (PULSE_CYCLES - 32'd1);
  wire [31:0] count_plus = count_q + 32'd1;

  always_comb begin
    state_d = state_q;
    count_d = 32'd0;
    wake_pulse_d = 1'b0;
    unique case (state_q)
      PLE_PD_AWAKE: begin
        if (!abort && idle_done) begin
          state_d = PLE_PD_ASLEEP;
        end else if (!abort) begin
          count_d = count_plus;
        end
      end
      PLE_PD_ASLEEP: begin
        if (abort) begin
          state_d = PLE_PD_AWAKE;
        end else if (pulse_enable && pulse_done) begin
          wake_pulse_d = 1'b1;
        end else if (pulse_enable) begin
          count_d = count_plus;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= PLE_PD_AWAKE;
      count_q <= 32'd0;
      wake_pulse_q <= 1'b0;
      in_powerdown_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      wake_pulse_q <= wake_pulse_d;
      in_powerdown_q <= state_d == PLE_PD_ASLEEP;
    end
  end

endmodule

`default_nettype wire

// [verilog/ple_err_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module ple_err_counter
  import ple_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic count_enable,
  input wire logic error_pulse,
  input wire logic clear_on_read,
  output logic [WIDTH-1:0] count_q
);

  ////////////////////////////////////////////////////////////////////////////
  // counting, saturating at all ones
  logic [WIDTH-1:0] count_d;
  wire increment = count_enable & error_pulse;
  wire at_max = &count_q;
  wire [WIDTH-1:0] count_plus = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
  wire [WIDTH-1:0] one_value = {{(WIDTH-1){1'b0}}, 1'b1};

  // an error in the cycle of the read is kept as the new count
  assign count_d = clear_on_read ? (increment ? one_value : '0) :
                   (increment && !at_max) ? count_plus : count_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count_q <= PLE_ERR_COUNT_RESET[WIDTH-1:0];
    end else begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

// [verilog/ple_loop_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - With all-digital loop select set, MAC transmit data returns on MAC receive data.
// - All-digital loopback acts only while the base control loopback bit is also set.
// - With line driver loop select set, line driver loopback runs while loopback is on and all-digital loop select is clear.
// - With far-end loop enabled, the link up and base loopback clear, remote receive data is sent back to it.
// - Cable loop enable stops cancelling the own transmit signal, with base loopback clear.
// - Transmit suppress set mutes the media transmit signal during all-digital loopback.
// - Loop link-ok force set shows link status okay during MII loopback.
// - A 16-bit frame checker error count clears on each read of its register, to one if an error comes in the read cycle.
// - Energy power-down enable set enters power-down after seconds with no line energy.
// - The energy power-down enable takes its reset default from a strap pin.
// - Power-down pulse enable set sends periodic pulse bursts while powered down.
// - Loopback register resets to 0x1041, counter and energy register to zero.
// - A read-only bit shows 1 while in energy power-down and 0 otherwise.
// - The frame checker counts errors only while the diagnostics clock is enabled.
module ple_loop_regs
  import ple_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int unsigned ENERGY_IDLE_CYCLES = PLE_ENERGY_IDLE_CYCLES,
  parameter int unsigned PULSE_PERIOD_CYCLES = PLE_PULSE_PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic ieee_loopback,
  input wire logic diagnostics_clock_enable,
  input wire logic link_up,
  input wire logic frame_check_error,
  input wire logic energy_detect_pin,
  input wire logic energy_pd_strap_pin,
  input wire logic pd_pulse_strap_pin,
  input wire logic [DATA_W-1:0] mac_txd,
  input wire logic mac_tx_en,
  input wire logic mac_tx_er,
  input wire logic [DATA_W-1:0] ana_rxd,
  input wire logic ana_rx_dv,
  input wire logic ana_rx_er,
  output logic [DATA_W-1:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic [DATA_W-1:0] ana_txd,
  output logic ana_tx_en,
  output logic ana_tx_er,
  output logic all_digital_loop_active,
  output logic line_driver_loop_active,
  output logic far_end_loop_active,
  output logic cable_loop_active,
  output logic mdi_tx_suppress,
  output logic link_ok,
  output logic in_energy_powerdown,
  output logic powerdown_pulse_burst
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] ofs);
    addr_hit = addr == ofs;
  endfunction

  wire hit_loop = addr_hit(mgmt_addr, PLE_OFS_LOOP_CTRL);
  wire hit_count = addr_hit(mgmt_addr, PLE_OFS_ERR_COUNT);
  wire hit_energy = addr_hit(mgmt_addr, PLE_OFS_ENERGY_CTRL);
  wire wr_loop = mgmt_wr & hit_loop;
  wire wr_energy = mgmt_wr & hit_energy;
  wire rd_count = mgmt_rd & hit_count;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_raw = {pd_pulse_strap_pin, energy_pd_strap_pin, energy_detect_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire energy_seen = sync2_q[0];
  wire energy_strap = sync2_q[1];
  wire pulse_strap = sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [1:0] strap_wait_q;
  logic strap_load_q;
  wire strap_last = strap_wait_q == 2'h1;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      strap_wait_q <= PLE_STRAP_SETTLE_CYCLES;
    end else begin
      strap_wait_q <= (strap_wait_q != 2'h0) ? strap_wait_q - 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      strap_load_q <= 1'b0;
    end else begin
      strap_load_q <= strap_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loopback control register
  logic [15:0] loop_ctrl_q;
  wire [15:0] loop_ctrl_d = wr_loop ? (mgmt_wdata & PLE_LOOP_CTRL_WMASK) : loop_ctrl_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      loop_ctrl_q <= PLE_LOOP_CTRL_RESET;
    end else begin
      loop_ctrl_q <= loop_ctrl_d;
    end
  end

  wire all_digital_loop_select = loop_ctrl_q[PLE_BIT_ALL_DIGITAL_LOOP];
  wire line_driver_loop_select = loop_ctrl_q[PLE_BIT_LINE_DRIVER_LOOP];
  wire far_end_loop_enable = loop_ctrl_q[PLE_BIT_FAR_END_LOOP];
  wire cable_loop_enable = loop_ctrl_q[PLE_BIT_CABLE_LOOP];
  wire loop_transmit_suppress = loop_ctrl_q[PLE_BIT_LOOP_TX_SUPPRESS];
  wire loop_link_ok_force = loop_ctrl_q[PLE_BIT_LOOP_LINK_OK];

  ////////////////////////////////////////////////////////////////////////////
  // energy detect control register
  logic energy_powerdown_enable_q;
  logic powerdown_pulse_enable_q;
  logic in_energy_powerdown_flag;
  logic pd_wake_pulse;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      energy_powerdown_enable_q <= PLE_ENERGY_CTRL_RESET[PLE_BIT_ENERGY_PD_ENABLE];
      powerdown_pulse_enable_q <= PLE_ENERGY_CTRL_RESET[PLE_BIT_PD_PULSE_ENABLE];
    end else if (wr_energy) begin
      energy_powerdown_enable_q <= mgmt_wdata[PLE_BIT_ENERGY_PD_ENABLE];
      powerdown_pulse_enable_q <= mgmt_wdata[PLE_BIT_PD_PULSE_ENABLE];
    end else if (strap_load_q) begin
      energy_powerdown_enable_q <= energy_strap;
      powerdown_pulse_enable_q <= pulse_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame checker error counter
  logic [15:0] err_count;

  ple_err_counter #(
    .WIDTH(16)
  ) u_err_counter (
    .clock(clock),
    .rst_b(rst_b),
    .count_enable(diagnostics_clock_enable),
    .error_pulse(frame_check_error),
    .clear_on_read(rd_count),
    .count_q(err_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // energy detect power-down
  ple_energy_pd #(
    .IDLE_CYCLES(ENERGY_IDLE_CYCLES),
    .PULSE_CYCLES(PULSE_PERIOD_CYCLES)
  ) u_energy_pd (
    .clock(clock),
    .rst_b(rst_b),
    .enable(energy_powerdown_enable_q),
    .pulse_enable(powerdown_pulse_enable_q),
    .energy_seen(energy_seen),
    .in_powerdown_q(in_energy_powerdown_flag),
    .wake_pulse_q(pd_wake_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [15:0] energy_read;
  logic [15:0] read_value;

  always_comb begin
    energy_read = 16'h0000;
    energy_read[PLE_BIT_ENERGY_PD_ENABLE] = energy_powerdown_enable_q;
    energy_read[PLE_BIT_PD_PULSE_ENABLE] = powerdown_pulse_enable_q;
    energy_read[PLE_BIT_IN_ENERGY_PD] = in_energy_powerdown_flag;
  end

  assign read_value = hit_loop ? loop_ctrl_q :
                      hit_count ? err_count :
                      hit_energy ? energy_read : 16'h0000;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mgmt_rdata <= 16'h0000;
    end else begin
      mgmt_rdata <= mgmt_rd ? read_value : mgmt_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loopback mode resolution
  wire all_dig_on = all_digital_loop_select & ieee_loopback;
  wire line_drv_on = line_driver_loop_select & ieee_loopback & ~all_digital_loop_select;
  wire far_end_on = far_end_loop_enable & link_up & ~ieee_loopback;
  wire cable_on = cable_loop_enable & ~ieee_loopback;
  wire suppress_on = all_dig_on & loop_transmit_suppress;
  wire link_ok_d = link_up | (ieee_loopback & loop_link_ok_force);

  ////////////////////////////////////////////////////////////////////////////
  // data path
  wire [DATA_W-1:0] rx_data_d = all_dig_on ? mac_txd : ana_rxd;
  wire rx_dv_d = all_dig_on ? mac_tx_en : ana_rx_dv;
  wire rx_er_d = all_dig_on ? mac_tx_er : ana_rx_er;
  wire [DATA_W-1:0] tx_data_d = far_end_on ? ana_rxd : mac_txd;
  wire tx_gate = ~suppress_on & ~in_energy_powerdown_flag;
  wire tx_en_d = (far_end_on ? ana_rx_dv : mac_tx_en) & tx_gate;
  wire tx_er_d = (far_end_on ? ana_rx_er : mac_tx_er) & tx_gate;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mac_rxd <= '0;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
    end else begin
      mac_rxd <= rx_data_d;
      mac_rx_dv <= rx_dv_d;
      mac_rx_er <= rx_er_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ana_txd <= '0;
      ana_tx_en <= 1'b0;
      ana_tx_er <= 1'b0;
    end else begin
      ana_txd <= tx_data_d;
      ana_tx_en <= tx_en_d;
      ana_tx_er <= tx_er_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and status outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      all_digital_loop_active <= 1'b0;
      line_driver_loop_active <= 1'b0;
      far_end_loop_active <= 1'b0;
      cable_loop_active <= 1'b0;
      mdi_tx_suppress <= 1'b0;
    end else begin
      all_digital_loop_active <= all_dig_on;
      line_driver_loop_active <= line_drv_on;
      far_end_loop_active <= far_end_on;
      cable_loop_active <= cable_on;
      mdi_tx_suppress <= suppress_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      link_ok <= 1'b0;
      in_energy_powerdown <= 1'b0;
      powerdown_pulse_burst <= 1'b0;
    end else begin
      link_ok <= link_ok_d;
      in_energy_powerdown <= in_energy_powerdown_flag;
      powerdown_pulse_burst <= pd_wake_pulse;
    end
  end

endmodule

`default_nettype wire
